// >>> hw/half_duplex_async_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module half_duplex_async_serial_port (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] baud_sel,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_write,
  output logic            tx_busy,
  output logic [7:0]      rx_data,
  input  wire logic       rx_read,
  output logic            rx_full,
  output logic            rx_framing_err,
  output logic            rx_overrun,
  output logic            data_irq,
  output logic            service_irq,
  input  wire logic       service_ack,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_drive
);

  typedef struct packed {
    serial_port_pkg::line_state_type st;
    logic [1:0]  sync;
    logic        line_q;
    logic [3:0]  sub;
    logic [3:0]  bitn;
    logic [10:0] shift;
    logic [7:0]  hold;
    logic        full;
    logic        ferr;
    logic        ovr;
    logic        tx_pend;
    logic [7:0]  tx_buf;
    logic        line_out;
    logic        line_drive;
    logic        data_irq;
    logic        service_irq;
    logic        tx_busy;
  } port_state_type;

  port_state_type s_r;
  port_state_type s_nxt;
  logic           tick;

  // Last of the sixteen ticks that make up one bit time
  function automatic logic slot_end(input logic [3:0] sub);
    return sub == 4'(serial_port_pkg::OVERSAMPLE - 1);
  endfunction : slot_end

  // Tick on which a bit is sampled, half a bit after its leading edge
  function automatic logic slot_centre(input logic [3:0] sub);
    return sub == 4'(serial_port_pkg::MID_SAMPLE - 1);
  endfunction : slot_centre

  // Last bit of the frame, the second stop bit
  function automatic logic frame_end(input logic [3:0] bitn);
    return bitn == 4'(serial_port_pkg::FRAME_BITS - 1);
  endfunction : frame_end

  // Frame laid out for shifting out least significant bit first: start, data, two stops
  function automatic logic [10:0] tx_frame(input logic [7:0] data);
    return {2'b11, data, 1'b0};
  endfunction : tx_frame

  // Character bits once start and eight data bits have been shifted in from the top
  function automatic logic [7:0] rx_char(input logic [10:0] shift);
    return shift[10:3];
  endfunction : rx_char

  // One divider serves both directions; half duplex never needs two bit phases at once
  baud_tick_gen u_tick (
    .clk      (clk),
    .reset    (reset),
    .baud_sel (baud_sel),
    .tick     (tick)
  );

  always_comb begin
    s_nxt          = s_r;
    s_nxt.data_irq = 1'b0;
    s_nxt.sync     = {s_r.sync[0], line_in};
    s_nxt.line_q   = s_r.sync[1];

    // Software read empties the holding register; a new character in the same cycle wins below
    if (rx_read) begin
      s_nxt.full = 1'b0;
    end

    // A flag raised later in this process overrides the acknowledge
    if (service_ack) begin
      s_nxt.ferr        = 1'b0;
      s_nxt.ovr         = 1'b0;
      s_nxt.service_irq = 1'b0;
    end

    // Write while a character is in flight is dropped; tx_busy tells the host to wait
    if (tx_write && !s_r.tx_pend && s_r.st != serial_port_pkg::ST_TX) begin
      s_nxt.tx_pend = 1'b1;
      s_nxt.tx_buf  = tx_data;
    end

    unique case (s_r.st)
      serial_port_pkg::ST_IDLE: begin
        s_nxt.line_drive = 1'b0;
        s_nxt.line_out   = 1'b1;
        // A start edge beats a queued transmit: the far end is already talking on the one line
        if (s_r.line_q && !s_r.sync[1]) begin
          s_nxt.st   = serial_port_pkg::ST_RX;
          s_nxt.sub  = '0;
          s_nxt.bitn = '0;
        end else if (s_r.tx_pend && tick) begin
          s_nxt.st         = serial_port_pkg::ST_TX;
          s_nxt.shift      = tx_frame(s_r.tx_buf);
          s_nxt.tx_pend    = 1'b0;
          s_nxt.sub        = '0;
          s_nxt.bitn       = '0;
          s_nxt.line_drive = 1'b1;
          s_nxt.line_out   = 1'b0;
        end
      end

      serial_port_pkg::ST_RX: begin
        // Sampling phase follows the first tick after the edge, so the centre may sit up to one tick early
        if (tick) begin
          s_nxt.sub = s_r.sub + 1'b1;
          if (slot_centre(s_r.sub)) begin
            s_nxt.shift = {s_r.sync[1], s_r.shift[10:1]};
            s_nxt.bitn  = s_r.bitn + 1'b1;
            if (s_r.bitn == 4'h0 && s_r.sync[1]) begin
              s_nxt.st = serial_port_pkg::ST_IDLE; // False start, glitch rejected
            end else if (s_r.bitn == 4'(serial_port_pkg::DATA_BITS + 1)) begin
              // First stop bit just sampled; it is still in sync[1], and shift holds data at [10:3]
              s_nxt.hold     = rx_char(s_r.shift);
              s_nxt.full     = 1'b1;
              s_nxt.data_irq = 1'b1;
              // Overrun keeps the newer character; the unread one is lost
              if (s_r.full && !rx_read) begin
                s_nxt.ovr         = 1'b1;
                s_nxt.service_irq = 1'b1;
              end
              if (!s_r.sync[1]) begin
                s_nxt.ferr        = 1'b1;
                s_nxt.service_irq = 1'b1;
              end
              s_nxt.st  = serial_port_pkg::ST_HOLD;
              s_nxt.sub = '0;
            end
          end
        end
      end

      serial_port_pkg::ST_HOLD: begin
        // Wait to the centre of the second stop bit; no legal start edge can come before it
        if (tick) begin
          s_nxt.sub = s_r.sub + 1'b1;
          if (slot_end(s_r.sub)) begin
            s_nxt.bitn = s_r.bitn + 1'b1;
            if (frame_end(s_r.bitn)) begin
              s_nxt.st = serial_port_pkg::ST_IDLE;
            end
          end
        end
      end

      serial_port_pkg::ST_TX: begin
        if (tick) begin
          s_nxt.sub = s_r.sub + 1'b1;
          if (slot_end(s_r.sub)) begin
            // shift[0] is the bit now on the line, so the next one comes from shift[1]
            s_nxt.shift    = {1'b1, s_r.shift[10:1]};
            s_nxt.line_out = s_r.shift[1];
            s_nxt.bitn     = s_r.bitn + 1'b1;
            if (frame_end(s_r.bitn)) begin
              s_nxt.st         = serial_port_pkg::ST_IDLE;
              s_nxt.line_out   = 1'b1;
              s_nxt.line_drive = 1'b0;
              // Transmit done: the host may queue the next character from here on
              s_nxt.data_irq   = 1'b1;
            end
          end
        end
      end
      default: s_nxt.st = serial_port_pkg::ST_IDLE;
    endcase
    // Busy covers a queued character as well as one on the line
    s_nxt.tx_busy = s_nxt.tx_pend || (s_nxt.st == serial_port_pkg::ST_TX);
  end

  // Synchroniser and edge detector start at the idle level, so reset release shows no false start
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r.st          <= serial_port_pkg::ST_IDLE;
      s_r.sync        <= {2{serial_port_pkg::LINE_IDLE}};
      s_r.line_q      <= serial_port_pkg::LINE_IDLE;
      s_r.sub         <= '0;
      s_r.bitn        <= '0;
      s_r.shift       <= '0;
      s_r.hold        <= '0;
      s_r.full        <= 1'b0;
      s_r.ferr        <= 1'b0;
      s_r.ovr         <= 1'b0;
      s_r.tx_pend     <= 1'b0;
      s_r.tx_buf      <= '0;
      s_r.tx_busy     <= 1'b0;
      s_r.line_out    <= serial_port_pkg::LINE_IDLE;
      s_r.line_drive  <= 1'b0;
      s_r.data_irq    <= 1'b0;
      s_r.service_irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_busy        = s_r.tx_busy;
  assign rx_data        = s_r.hold;
  assign rx_full        = s_r.full;
  assign rx_framing_err = s_r.ferr;
  assign rx_overrun     = s_r.ovr;
  assign data_irq       = s_r.data_irq;
  assign service_irq    = s_r.service_irq;
  assign line_out       = s_r.line_out;
  assign line_drive     = s_r.line_drive;

endmodule : half_duplex_async_serial_port
`default_nettype wire

// >>> shared/serial_port_pkg.sv
package serial_port_pkg;

  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned STOP_BITS    = 2;
  localparam int unsigned FRAME_BITS   = 1 + DATA_BITS + STOP_BITS;
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned MID_SAMPLE   = OVERSAMPLE / 2;
  localparam logic        LINE_IDLE    = 1'b1;

  localparam logic [3:0] BAUD_110  = 4'h0;
  localparam logic [3:0] BAUD_150  = 4'h1;
  localparam logic [3:0] BAUD_300  = 4'h2;
  localparam logic [3:0] BAUD_600  = 4'h3;
  localparam logic [3:0] BAUD_1200 = 4'h4;
  localparam logic [3:0] BAUD_1800 = 4'h5;
  localparam logic [3:0] BAUD_2400 = 4'h6;
  localparam logic [3:0] BAUD_4800 = 4'h7;
  localparam logic [3:0] BAUD_9600 = 4'h8;
  localparam logic [3:0] BAUD_RESET = BAUD_9600;

  localparam int unsigned DIV_W = 16;

  // Divider reload: clock cycles per sixteenth of a bit, rounded down, minus one
  function automatic logic [DIV_W-1:0] tick_div(input logic [3:0] sel);
    int unsigned rate;
    unique case (sel)
      BAUD_110:  rate = 110;
      BAUD_150:  rate = 150;
      BAUD_300:  rate = 300;
      BAUD_600:  rate = 600;
      BAUD_1200: rate = 1200;
      BAUD_1800: rate = 1800;
      BAUD_2400: rate = 2400;
      BAUD_4800: rate = 4800;
      default:   rate = 9600;
    endcase
    tick_div = DIV_W'(CLK_HZ / (rate * OVERSAMPLE) - 1);
  endfunction : tick_div

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX   = 4'b0010,
    ST_TX   = 4'b0100,
    ST_HOLD = 4'b1000
  } line_state_type;

endpackage : serial_port_pkg

// >>> hw/baud_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] baud_sel,
  output logic            tick
);

  typedef struct packed {
    logic [serial_port_pkg::DIV_W-1:0] cnt;
    logic                              tick;
  } tick_state_type;

  tick_state_type s_r;
  tick_state_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == '0) begin
      s_nxt.cnt  = serial_port_pkg::tick_div(baud_sel);
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule : baud_tick_gen
`default_nettype wire

// >>> tb/port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module port_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [3:0] baud_sel,
  input wire logic       tx_write,
  input wire logic       tx_busy,
  input wire logic [7:0] rx_data,
  input wire logic       rx_full,
  input wire logic       rx_framing_err,
  input wire logic       data_irq,
  input wire logic       service_irq,
  input wire logic       line_out,
  input wire logic       line_drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Frame length is only checked at the fastest rate, the one the bench runs
  logic [16:0] drv_cnt_r;
  always_ff @(posedge clk) drv_cnt_r <= (reset || !line_drive) ? 17'h0 : drv_cnt_r + 17'h1;
  half_duplex_a:
    assert property (line_drive |-> !$rose(rx_full)) else $error("receive done while driving");
  idle_high_a:
    assert property (!line_drive |-> line_out) else $error("line not idle high");
  start_low_a:
    assert property ($rose(line_drive) |-> !line_out) else $error("no start bit");
  stop_high_a:
    assert property ($fell(line_drive) |-> $past(line_out)) else $error("stop bit low");
  frame_len_a:
    assert property ($fell(line_drive) && baud_sel == serial_port_pkg::BAUD_9600 |-> drv_cnt_r == 17'hDF70)
      else $error("frame length wrong");
  tx_take_a:
    assert property (tx_write && !tx_busy && !line_drive |=> tx_busy) else $error("write not taken");
  rx_hold_a:
    assert property ($changed(rx_data) |-> data_irq && rx_full) else $error("holding changed alone");
  svc_cause_a:
    assert property ($rose(rx_framing_err) |-> service_irq) else $error("no service request");
  irq_pulse_a:
    assert property (data_irq |=> !data_irq) else $error("data interrupt longer than one cycle");
endmodule : port_chk
bind half_duplex_async_serial_port port_chk u_chk (.clk(clk), .reset(reset), .baud_sel(baud_sel),
  .tx_write(tx_write), .tx_busy(tx_busy), .rx_data(rx_data), .rx_full(rx_full), .rx_framing_err(rx_framing_err),
  .data_irq(data_irq), .service_irq(service_irq), .line_out(line_out), .line_drive(line_drive));
`default_nettype wire

// >>> tb/term_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bit time of 5200 clocks matches 9600 baud at 50 MHz with 16 ticks a bit
module term_model #(parameter int BIT = 5200) (
  input  wire logic       clk,
  input  wire logic       line_out,
  input  wire logic       line_drive,
  input  wire logic       go,
  input  wire logic [7:0] send_byte,
  input  wire logic       bad_stop,
  output logic            line_in,
  output logic [7:0]      got_byte,
  output int              n_got
);
  initial begin
    line_in = 1'b1;
    got_byte = 8'h00;
    n_got = 0;
  end
  always @(posedge clk) begin
    if (line_drive && !line_out) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        got_byte[i] = line_out;
      end
      n_got = n_got + 1;
      wait (!line_drive);
    end
  end
  // Line idles at mark; a low first stop bit only when the bench asks for it
  always @(posedge clk) begin
    if (go) begin
      line_in <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        line_in <= send_byte[i];
        repeat (BIT) @(posedge clk);
      end
      line_in <= !bad_stop;
      repeat (BIT) @(posedge clk);
      line_in <= 1'b1;
    end
  end
endmodule : term_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, reset, tx_write, rx_read, service_ack, go, bad_stop;
  logic [3:0] baud_sel;
  logic [7:0] tx_data, send_byte, rx_data, got_byte, lfsr_r;
  logic       tx_busy, rx_full, rx_framing_err, rx_overrun, data_irq, service_irq, line_in, line_out, line_drive;
  int         n_got, n_fail, checked, n_irq;
  half_duplex_async_serial_port u_dut (.clk(clk), .reset(reset), .baud_sel(baud_sel), .tx_data(tx_data),
    .tx_write(tx_write), .tx_busy(tx_busy), .rx_data(rx_data), .rx_read(rx_read), .rx_full(rx_full),
    .rx_framing_err(rx_framing_err), .rx_overrun(rx_overrun), .data_irq(data_irq), .service_irq(service_irq),
    .service_ack(service_ack), .line_in(line_in), .line_out(line_out), .line_drive(line_drive));
  term_model u_term (.clk(clk), .line_out(line_out), .line_drive(line_drive), .go(go), .send_byte(send_byte),
    .bad_stop(bad_stop), .line_in(line_in), .got_byte(got_byte), .n_got(n_got));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Two frames of 57200 clocks each, plus margin
  initial begin
    #2300000;
    n_fail++;
    final_report();
  end
  // Counted on the falling edge, away from the launch edge, so each one-cycle pulse is seen exactly once
  always @(negedge clk) begin
    if (data_irq === 1'b1) begin
      n_irq++;
    end
  end
  initial begin
    {reset, tx_write, rx_read, service_ack, go, bad_stop} = 6'h20;
    baud_sel = serial_port_pkg::BAUD_9600;
    {tx_data, send_byte} = 16'h0000;
    lfsr_r = 8'h23;
    n_fail = 0;
    checked = 0;
    n_irq = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    lfsr_r = lfsr_next(lfsr_r);
    tx_data = lfsr_r;
    tx_write = 1'b1;
    @(negedge clk);
    check(8'h01, {7'h0, tx_busy});
    tx_data = ~lfsr_r;
    @(negedge clk);
    tx_write = 1'b0;
    for (int k = 0; k < 70000 && tx_busy; k++) @(negedge clk);
    repeat (400) @(negedge clk);
    check(8'h01, {5'h0, tx_busy, line_drive, line_out});
    check(lfsr_r, got_byte);
    check(8'h01, 8'(n_got));
    $display("tx test done");
    lfsr_r = lfsr_next(lfsr_r);
    send_byte = lfsr_r;
    bad_stop = 1'b1;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int k = 0; k < 60000 && !rx_full; k++) @(negedge clk);
    check(8'h01, {7'h0, rx_full});
    check(lfsr_r, rx_data);
    check(8'h03, {5'h0, rx_overrun, rx_framing_err, service_irq});
    service_ack = 1'b1;
    @(negedge clk);
    service_ack = 1'b0;
    rx_read = 1'b1;
    @(negedge clk);
    rx_read = 1'b0;
    check(8'h00, {5'h0, rx_full, rx_framing_err, service_irq});
    check(8'h02, 8'(n_irq));
    $display("rx test done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
